// ===== include/astr_pkg.sv
// package: register map, field positions, reset values and timing counts of the serial port
package astr_pkg;
    localparam logic [7:0] OFS_RCSTA = 8'h00;
    localparam logic [7:0] OFS_TXBUF = 8'h04;
    localparam logic [7:0] OFS_TXSTA = 8'h08;
    localparam logic [7:0] OFS_BAUD = 8'h0c;
    localparam logic [7:0] OFS_RXDATA = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h14;
    localparam logic [7:0] OFS_IRQEN = 8'h18;
    localparam int RC_PORT_ENABLE = 7;
    localparam int RC_RX9 = 6;
    localparam int RC_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int RC_ADDRESS_DETECT_ENABLE = 3;
    localparam int TX_NINE = 6;
    localparam int TX_EN = 5;
    localparam int TX_SYNC = 4;
    localparam int TX_HIGH_SPEED_BAUD_SELECT = 2;
    localparam int FL_TXBE = 4;
    localparam int FL_RXC = 5;
    localparam logic [7:0] RCSTA_RST = 8'h00;
    localparam logic [7:0] TXSTA_RST = 8'h02;
    localparam logic [7:0] TXBUF_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] RCSTA_WMASK = 8'hf8;
    localparam logic [7:0] TXSTA_WMASK = 8'hf5;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_PT = 4'h8;
    localparam logic [1:0] PRE_LAST = 2'h3;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] NINE_BITS = 4'h9;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} astr_txst_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} astr_rxst_t;
endpackage

// ===== include/astr_line_if.sv
// interface: sample tick and recovered receive line between port submodules
`timescale 1ns/1ps
interface astr_line_if;
    logic tick;
    logic rx_level;
    logic rx_bit;
    modport baud (output tick);
    modport samp (input tick, output rx_level, output rx_bit);
    modport core (input tick, input rx_level, input rx_bit);
endinterface

// ===== core/astr_baud.sv
// module: baud divisor producing the sixteen-times sample tick
`timescale 1ns/1ps
module astr_baud #(
    parameter int DW = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic en_i,
    input wire logic high_speed_baud_select_i,
    input wire logic [DW-1:0] div_i,
    astr_line_if.baud ln
);
    typedef struct packed {
        logic [DW-1:0] cnt;
        logic [1:0] pre;
        logic tick;
    } astr_bd_t;
    astr_bd_t q, d;

    // low speed divides the raw tick by four so the sampler always sees 16x
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!en_i) begin
            d.cnt = div_i;
            d.pre = 2'h0;
        end else if (q.cnt == '0) begin
            d.cnt = div_i;
            if (high_speed_baud_select_i || q.pre == astr_pkg::PRE_LAST) begin
                d.pre = 2'h0;
                d.tick = 1'b1;
            end else begin
                d.pre = q.pre + 2'h1;
            end
        end else begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign ln.tick = q.tick;
endmodule // astr_baud

// ===== core/astr_samp.sv
// module: receive pin synchroniser and majority-vote data recovery
`timescale 1ns/1ps
module astr_samp (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic rx_pin_i,
    astr_line_if.samp ln
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic [2:0] win;
    } astr_sp_t;
    localparam astr_sp_t SP_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1, win: 3'h7};
    astr_sp_t q, d;

    // level moves only once the two later stages agree, filtering single glitches
    always_comb begin
        d = q;
        d.s1 = rx_pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
        if (ln.tick) begin
            d.win = {q.win[1:0], q.lvl};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= SP_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign ln.rx_level = q.lvl;
    assign ln.rx_bit = (q.win[0] & q.win[1]) | (q.win[1] & q.win[2]) | (q.win[0] & q.win[2]);
endmodule // astr_samp

// ===== core/astr_top.sv
// module: asynchronous serial transmit and receive port with wishbone registers
`timescale 1ns/1ps
module astr_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic sleep_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_pin_i,
    output logic tx_pin_o,
    output logic tx_irq_o,
    output logic rx_irq_o
);
    typedef struct packed {
        logic [7:0] rcctl;
        logic framing_error;
        logic overrun_error;
        logic rx_ninth_bit;
        logic [7:0] txsta;
        logic [7:0] txbuf;
        logic txfull;
        logic txflag;
        logic clr_pend;
        logic [7:0] baud;
        logic txie;
        logic rcie;
        logic [7:0] rxdata;
        logic rxflag;
        astr_pkg::astr_txst_t txs;
        logic [8:0] txsh;
        logic [3:0] txcnt;
        logic [3:0] txsub;
        logic txpin;
        astr_pkg::astr_rxst_t rxs;
        logic [8:0] rxsh;
        logic [3:0] rxcnt;
        logic [3:0] rxsub;
        logic ack;
        logic [31:0] dat;
        logic txirq;
        logic rxirq;
    } astr_st_t;

    // one reset image serves every port instance alike
    localparam astr_st_t ST_RST = '{
        rcctl: astr_pkg::RCSTA_RST,
        txsta: astr_pkg::TXSTA_RST,
        txbuf: astr_pkg::TXBUF_RST,
        baud: astr_pkg::BAUD_RST,
        txs: astr_pkg::TX_IDLE,
        rxs: astr_pkg::RX_IDLE,
        txpin: 1'b1,
        default: '0
    };

    astr_st_t q, d;
    logic [7:0] rd_val;
    logic req;
    logic acc_wr;
    logic acc_rd;
    logic wr_txb;
    logic rd_rx;
    logic transmit_enable_rise;
    logic tx_on;
    logic rx_on;
    logic tx_load;
    logic tx_shifter_empty;
    logic tick;
    logic bd_en;
    logic rx_done;
    logic ninth;
    logic [7:0] rx_byte;
    logic skip;
    logic rx_store;
    logic rx_ovr;

    astr_line_if ln ();

    // sleep stops the tick, which freezes both engines mid-frame
    assign bd_en = q.rcctl[astr_pkg::RC_PORT_ENABLE] && !sleep_i;

    astr_baud #(
        .DW(8)
    ) u_baud (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .en_i(bd_en),
        .high_speed_baud_select_i(q.txsta[astr_pkg::TX_HIGH_SPEED_BAUD_SELECT]),
        .div_i(q.baud),
        .ln(ln.baud)
    );

    astr_samp u_samp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .rx_pin_i(rx_pin_i),
        .ln(ln.samp)
    );

    assign tick = ln.tick;
    // byte lane 0 carries every register; other lanes are ignored
    assign req = wb_cyc_i && wb_stb_i;
    assign acc_wr = req && wb_we_i && q.ack && wb_sel_i[0];
    assign acc_rd = req && !wb_we_i && q.ack;
    assign wr_txb = acc_wr && wb_adr_i == astr_pkg::OFS_TXBUF;
    assign rd_rx = acc_rd && wb_adr_i == astr_pkg::OFS_RXDATA;
    assign transmit_enable_rise = acc_wr && wb_adr_i == astr_pkg::OFS_TXSTA
        && wb_dat_i[astr_pkg::TX_EN] && !q.txsta[astr_pkg::TX_EN];

    assign tx_on = q.txsta[astr_pkg::TX_EN] && q.rcctl[astr_pkg::RC_PORT_ENABLE]
        && !q.txsta[astr_pkg::TX_SYNC];
    assign tx_load = tx_on && q.txfull && q.txs == astr_pkg::TX_IDLE;
    assign tx_shifter_empty = q.txs == astr_pkg::TX_IDLE;

    // an overrun holds the receiver off until software drops continuous receive
    assign rx_on = q.rcctl[astr_pkg::RC_PORT_ENABLE] && q.rcctl[astr_pkg::RC_CONTINUOUS_RECEIVE_ENABLE]
        && !q.txsta[astr_pkg::TX_SYNC] && !q.overrun_error;
    assign rx_done = rx_on && tick && q.rxs == astr_pkg::RX_STOP
        && q.rxsub == astr_pkg::SAMPLE_PT;
    assign ninth = q.rcctl[astr_pkg::RC_RX9] && q.rxsh[8];
    assign rx_byte = q.rcctl[astr_pkg::RC_RX9] ? q.rxsh[7:0] : q.rxsh[8:1];
    assign skip = q.rcctl[astr_pkg::RC_ADDRESS_DETECT_ENABLE] && q.rcctl[astr_pkg::RC_RX9] && !ninth;
    assign rx_store = rx_done && !skip && (!q.rxflag || rd_rx);
    assign rx_ovr = rx_done && !skip && q.rxflag && !rd_rx;

    // the shifter contents never appear in this map; only its empty status does, at TXSTA bit 1
    always_comb begin
        rd_val = 8'h00;
        if (wb_adr_i == astr_pkg::OFS_RCSTA) begin
            rd_val = {q.rcctl[7:3], q.framing_error, q.overrun_error, q.rx_ninth_bit};
        end else if (wb_adr_i == astr_pkg::OFS_TXBUF) begin
            rd_val = q.txbuf;
        end else if (wb_adr_i == astr_pkg::OFS_TXSTA) begin
            rd_val = {q.txsta[7:2], tx_shifter_empty, q.txsta[0]};
        end else if (wb_adr_i == astr_pkg::OFS_BAUD) begin
            rd_val = q.baud;
        end else if (wb_adr_i == astr_pkg::OFS_RXDATA) begin
            rd_val = q.rxdata;
        end else if (wb_adr_i == astr_pkg::OFS_FLAGS) begin
            rd_val[astr_pkg::FL_TXBE] = q.txflag;
            rd_val[astr_pkg::FL_RXC] = q.rxflag;
        end else if (wb_adr_i == astr_pkg::OFS_IRQEN) begin
            rd_val[astr_pkg::FL_TXBE] = q.txie;
            rd_val[astr_pkg::FL_RXC] = q.rcie;
        end
    end

    always_comb begin
        d = q;
        d.ack = req && !q.ack;
        if (req && !q.ack) begin
            d.dat = {24'h000000, rd_val};
        end
        // flag register writes fall through: flags are hardware-owned
        if (acc_wr) begin
            if (wb_adr_i == astr_pkg::OFS_RCSTA) begin
                d.rcctl = wb_dat_i[7:0] & astr_pkg::RCSTA_WMASK;
            end else if (wb_adr_i == astr_pkg::OFS_TXSTA) begin
                d.txsta = wb_dat_i[7:0] & astr_pkg::TXSTA_WMASK;
            end else if (wb_adr_i == astr_pkg::OFS_BAUD) begin
                d.baud = wb_dat_i[7:0];
            end else if (wb_adr_i == astr_pkg::OFS_IRQEN) begin
                d.txie = wb_dat_i[astr_pkg::FL_TXBE];
                d.rcie = wb_dat_i[astr_pkg::FL_RXC];
            end
        end

        // transmit holding buffer and its flag
        d.clr_pend = wr_txb;
        if (tx_load) begin
            d.txfull = 1'b0;
        end
        if (wr_txb) begin
            d.txbuf = wb_dat_i[7:0];
            d.txfull = 1'b1;
        end
        if (tx_load || transmit_enable_rise) begin
            d.txflag = 1'b1;
        end else if (q.clr_pend) begin
            d.txflag = 1'b0;
        end

        // transmit shifter
        if (!tx_on) begin
            d.txs = astr_pkg::TX_IDLE;
            d.txpin = 1'b1;
        end else begin
            case (q.txs)
                astr_pkg::TX_IDLE: begin
                    if (tx_load) begin
                        d.txsh = {q.txsta[0], q.txbuf};
                        d.txcnt = q.txsta[astr_pkg::TX_NINE] ? astr_pkg::NINE_BITS
                            : astr_pkg::DATA_BITS;
                        d.txsub = 4'h0;
                        d.txs = astr_pkg::TX_START;
                        d.txpin = 1'b0;
                    end
                end
                astr_pkg::TX_START, astr_pkg::TX_DATA, astr_pkg::TX_STOP: begin
                    if (tick) begin
                        d.txsub = q.txsub + 4'h1;
                        if (q.txsub == astr_pkg::OVS_LAST) begin
                            if (q.txs == astr_pkg::TX_STOP) begin
                                d.txs = astr_pkg::TX_IDLE;
                            end else if (q.txs == astr_pkg::TX_DATA && q.txcnt == 4'h0) begin
                                d.txs = astr_pkg::TX_STOP;
                                d.txpin = 1'b1;
                            end else begin
                                d.txs = astr_pkg::TX_DATA;
                                d.txpin = q.txsh[0];
                                d.txsh = {1'b0, q.txsh[8:1]};
                                d.txcnt = q.txcnt - 4'h1;
                            end
                        end
                    end
                end
                default: begin
                    d.txs = astr_pkg::TX_IDLE;
                end
            endcase
        end

        // receive shifter, sampled mid-bit from the majority window
        if (!rx_on) begin
            d.rxs = astr_pkg::RX_IDLE;
        end else begin
            case (q.rxs)
                astr_pkg::RX_IDLE: begin
                    if (!ln.rx_level) begin
                        d.rxs = astr_pkg::RX_START;
                        d.rxsub = 4'h0;
                    end
                end
                astr_pkg::RX_START, astr_pkg::RX_DATA, astr_pkg::RX_STOP: begin
                    if (tick) begin
                        d.rxsub = q.rxsub + 4'h1;
                        if (q.rxsub == astr_pkg::SAMPLE_PT) begin
                            if (q.rxs == astr_pkg::RX_START && ln.rx_bit) begin
                                d.rxs = astr_pkg::RX_IDLE;
                            end else if (q.rxs == astr_pkg::RX_DATA) begin
                                d.rxsh = {ln.rx_bit, q.rxsh[8:1]};
                                d.rxcnt = q.rxcnt - 4'h1;
                            end else if (q.rxs == astr_pkg::RX_STOP) begin
                                d.rxs = astr_pkg::RX_IDLE;
                            end
                        end else if (q.rxsub == astr_pkg::OVS_LAST) begin
                            if (q.rxs == astr_pkg::RX_START) begin
                                d.rxs = astr_pkg::RX_DATA;
                                d.rxcnt = q.rcctl[astr_pkg::RC_RX9] ? astr_pkg::NINE_BITS
                                    : astr_pkg::DATA_BITS;
                            end else if (q.rxs == astr_pkg::RX_DATA && q.rxcnt == 4'h0) begin
                                d.rxs = astr_pkg::RX_STOP;
                            end
                        end
                    end
                end
                default: begin
                    d.rxs = astr_pkg::RX_IDLE;
                end
            endcase
        end

        // a store in the same cycle as a data read wins, so no character is lost
        if (rx_store) begin
            d.rxdata = rx_byte;
            d.rx_ninth_bit = ninth;
            d.framing_error = !ln.rx_bit;
            d.rxflag = 1'b1;
        end else if (rd_rx) begin
            d.rxflag = 1'b0;
        end
        if (rx_ovr) begin
            d.overrun_error = 1'b1;
        end
        if (!q.rcctl[astr_pkg::RC_CONTINUOUS_RECEIVE_ENABLE]) begin
            d.overrun_error = 1'b0;
            d.framing_error = 1'b0;
        end

        d.txirq = q.txflag && q.txie;
        d.rxirq = q.rxflag && q.rcie;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= ST_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end

    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign tx_pin_o = q.txpin;
    assign tx_irq_o = q.txirq;
    assign rx_irq_o = q.rxirq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || !ce_i);

    property p_load_after_stop;
        tx_load |-> q.txs == astr_pkg::TX_IDLE && q.txpin;
    endproperty
    a_load_after_stop: assert property (p_load_after_stop)
        else $error("shifter loaded before stop bit finished");

    property p_flag_on_load;
        tx_load && !wr_txb |=> q.txflag && !q.txfull;
    endproperty
    a_flag_on_load: assert property (p_flag_on_load)
        else $error("buffer move did not set flag and empty buffer");

    property p_flag_fall;
        $fell(q.txflag) |-> $past(q.clr_pend);
    endproperty
    a_flag_fall: assert property (p_flag_fall)
        else $error("buffer-empty flag cleared without buffer write");

    property p_tx_irq;
        1'b1 |=> tx_irq_o == $past(q.txflag && q.txie);
    endproperty
    a_tx_irq: assert property (p_tx_irq)
        else $error("transmit interrupt does not follow flag and enable");

    property p_tx_shifter_empty_busy;
        tx_load |=> !tx_shifter_empty ##1 !tx_shifter_empty;
    endproperty
    a_tx_shifter_empty_busy: assert property (p_tx_shifter_empty_busy)
        else $error("shifter-empty set while shifting");

    property p_transmit_enable_flag;
        transmit_enable_rise |=> q.txflag;
    endproperty
    a_transmit_enable_flag: assert property (p_transmit_enable_flag)
        else $error("transmit enable did not set flag");

    property p_flag_delay;
        wr_txb && q.txflag && !tx_load |=> q.txflag;
    endproperty
    a_flag_delay: assert property (p_flag_delay)
        else $error("flag cleared too early after buffer write");

    property p_flag_clear;
        wr_txb && !tx_load ##1 !tx_load && !transmit_enable_rise |=> !q.txflag;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag not cleared two cycles after buffer write");

    property p_rx_off;
        !rx_on |=> q.rxs == astr_pkg::RX_IDLE;
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("receiver running while disabled");

    property p_rx_flag;
        rx_store |=> q.rxflag && q.rxdata == $past(rx_byte);
    endproperty
    a_rx_flag: assert property (p_rx_flag)
        else $error("received character not buffered and flagged");

    property p_err_clear;
        !q.rcctl[astr_pkg::RC_CONTINUOUS_RECEIVE_ENABLE] |=> !q.overrun_error && !q.framing_error;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("errors survive continuous receive disable");

    property p_addr_filter;
        rx_done && q.rcctl[astr_pkg::RC_ADDRESS_DETECT_ENABLE] && q.rcctl[astr_pkg::RC_RX9] && !q.rxsh[8]
            |=> $stable(q.rxdata) && q.rxflag == $past(q.rxflag && !rd_rx);
    endproperty
    a_addr_filter: assert property (p_addr_filter)
        else $error("non-address character reached receive buffer");

    property p_framing_error;
        rx_store && !ln.rx_bit |=> q.framing_error;
    endproperty
    a_framing_error: assert property (p_framing_error)
        else $error("low stop bit did not set framing error");

    property p_overrun;
        rx_ovr |=> q.overrun_error && !rx_on;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged or receiver not stopped");
endmodule // astr_top

// ===== dv/astr_peer.sv
// partner: remote serial station driving the receive line and decoding the transmit line
`timescale 1ns/1ps
module astr_peer (
    input wire logic clk_i,
    input wire logic tx_line_i,
    output logic rx_line_o
);
    logic [8:0] got = 9'h000;
    logic [8:0] sh = 9'h000;
    int n_got = 0;
    int nbits = 8;
    int bit_clk = 16;
    initial rx_line_o = 1'b1;
    // divisor 0: 16 clocks per bit with high speed select, 64 without
    task automatic send(input logic [8:0] d, input int nb, input logic stop);
        rx_line_o <= 1'b0;
        repeat (bit_clk) @(posedge clk_i);
        for (int i = 0; i < nb; i++) begin
            rx_line_o <= d[i];
            repeat (bit_clk) @(posedge clk_i);
        end
        rx_line_o <= stop;
        repeat (bit_clk) @(posedge clk_i);
        // idle is high as with a pull-up; long gap so a low stop is not taken as a start
        rx_line_o <= 1'b1;
        repeat (32) @(posedge clk_i);
    endtask
    // mid-bit recheck rejects a start bit that is high again within half a bit time
    always begin
        @(negedge tx_line_i);
        repeat (bit_clk / 2) @(posedge clk_i);
        if (tx_line_i === 1'b0) begin
            sh = 9'h000;
            for (int i = 0; i < nbits; i++) begin
                repeat (bit_clk) @(posedge clk_i);
                sh[i] = tx_line_i;
            end
            repeat (bit_clk) @(posedge clk_i);
            // a missing stop bit spoils the character
            got = (tx_line_i === 1'b1) ? sh : 9'h1ff;
            n_got++;
        end
    end
endmodule // astr_peer

// ===== dv/testbench.sv
// testbench: register, transmit and receive sequences for the serial port
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sleep = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack, tx_pin, tx_irq, rx_irq, rx_line;
    logic [7:0] q;
    int n_fail = 0;
    int tests_run = 0;
    always #2 clk_i = ~clk_i;
    astr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .sleep_i(sleep),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_pin_i(rx_line),
        .tx_pin_o(tx_pin), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
    astr_peer u_peer (.clk_i(clk_i), .tx_line_i(tx_pin), .rx_line_o(rx_line));
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) chk("ack", 9'h001, 9'h000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        wb(1'b0, a, 8'h00);
        chk(what, {1'b0, exp}, {1'b0, q});
    endtask
    task automatic txw(input int k);
        int n = 0;
        while (u_peer.n_got < k && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(astr_pkg::OFS_TXSTA, 8'h02, "txsta reset");
        rd(astr_pkg::OFS_RCSTA, 8'h00, "rcsta reset");
        rd(astr_pkg::OFS_BAUD, 8'h00, "baud reset");
        rd(astr_pkg::OFS_FLAGS, 8'h00, "flags reset");
        rd(8'h40, 8'h00, "unmapped");
        $display("test reset done");
        wb(1'b1, astr_pkg::OFS_BAUD, 8'h00);
        wb(1'b1, astr_pkg::OFS_RCSTA, 8'h80);
        wb(1'b1, astr_pkg::OFS_IRQEN, 8'h10);
        wb(1'b1, astr_pkg::OFS_TXSTA, 8'h24);
        rd(astr_pkg::OFS_FLAGS, 8'h10, "flag on enable");
        chk("tx irq on", 9'h001, {8'h00, tx_irq});
        wb(1'b1, astr_pkg::OFS_FLAGS, 8'h00);
        rd(astr_pkg::OFS_FLAGS, 8'h10, "flag not clearable");
        wb(1'b1, astr_pkg::OFS_TXBUF, 8'h5a);
        wb(1'b1, astr_pkg::OFS_TXBUF, 8'hc3);
        rd(astr_pkg::OFS_FLAGS, 8'h00, "buffer full");
        chk("tx irq off", 9'h000, {8'h00, tx_irq});
        rd(astr_pkg::OFS_TXSTA, 8'h24, "shifter busy");
        txw(1);
        chk("first char", 9'h05a, u_peer.got);
        txw(2);
        chk("second char", 9'h0c3, u_peer.got);
        repeat (20) @(posedge clk_i);
        rd(astr_pkg::OFS_TXSTA, 8'h26, "shifter empty");
        rd(astr_pkg::OFS_FLAGS, 8'h10, "buffer empty");
        u_peer.nbits = 9;
        wb(1'b1, astr_pkg::OFS_TXSTA, 8'h65);
        wb(1'b1, astr_pkg::OFS_TXBUF, 8'h11);
        txw(3);
        chk("nine bit char", 9'h111, u_peer.got);
        u_peer.nbits = 8;
        u_peer.bit_clk = 64;
        wb(1'b1, astr_pkg::OFS_TXSTA, 8'h20);
        wb(1'b1, astr_pkg::OFS_TXBUF, 8'h96);
        txw(4);
        chk("low speed char", 9'h096, u_peer.got);
        u_peer.bit_clk = 16;
        wb(1'b1, astr_pkg::OFS_TXSTA, 8'h24);
        $display("test transmit done");
        wb(1'b1, astr_pkg::OFS_RCSTA, 8'h90);
        wb(1'b1, astr_pkg::OFS_IRQEN, 8'h20);
        u_peer.send(9'h0a5, 8, 1'b1);
        rd(astr_pkg::OFS_FLAGS, 8'h30, "rx flag");
        chk("rx irq", 9'h001, {8'h00, rx_irq});
        chk("tx irq masked", 9'h000, {8'h00, tx_irq});
        rd(astr_pkg::OFS_RCSTA, 8'h90, "rx status");
        rd(astr_pkg::OFS_RXDATA, 8'ha5, "rx data");
        rd(astr_pkg::OFS_FLAGS, 8'h10, "rx flag read clear");
        u_peer.send(9'h03c, 8, 1'b0);
        rd(astr_pkg::OFS_RCSTA, 8'h94, "framing");
        u_peer.send(9'h077, 8, 1'b1);
        rd(astr_pkg::OFS_RCSTA, 8'h96, "overrun");
        rd(astr_pkg::OFS_RXDATA, 8'h3c, "kept char");
        u_peer.send(9'h055, 8, 1'b1);
        rd(astr_pkg::OFS_FLAGS, 8'h10, "stopped rx");
        wb(1'b1, astr_pkg::OFS_RCSTA, 8'h80);
        rd(astr_pkg::OFS_RCSTA, 8'h80, "errors cleared");
        $display("test receive done");
        wb(1'b1, astr_pkg::OFS_RCSTA, 8'hc0);
        wb(1'b1, astr_pkg::OFS_RCSTA, 8'hc8);
        wb(1'b1, astr_pkg::OFS_RCSTA, 8'hd8);
        u_peer.send(9'h012, 9, 1'b1);
        rd(astr_pkg::OFS_FLAGS, 8'h10, "data dropped");
        u_peer.send(9'h1a7, 9, 1'b1);
        rd(astr_pkg::OFS_RCSTA, 8'hd9, "address ninth");
        rd(astr_pkg::OFS_RXDATA, 8'ha7, "address data");
        wb(1'b1, astr_pkg::OFS_RCSTA, 8'hd0);
        u_peer.send(9'h034, 9, 1'b1);
        rd(astr_pkg::OFS_RXDATA, 8'h34, "all data");
        $display("test address detect done");
        wb(1'b1, astr_pkg::OFS_TXSTA, 8'h34);
        u_peer.send(9'h0f0, 9, 1'b1);
        rd(astr_pkg::OFS_FLAGS, 8'h10, "sync mode rx off");
        wb(1'b1, astr_pkg::OFS_TXSTA, 8'h24);
        sleep <= 1'b1;
        u_peer.send(9'h0f0, 9, 1'b1);
        rd(astr_pkg::OFS_FLAGS, 8'h10, "sleep rx halt");
        // clock enable low freezes the port while a character passes by
        sleep <= 1'b0;
        ce <= 1'b0;
        u_peer.send(9'h0f0, 9, 1'b1);
        ce <= 1'b1;
        repeat (32) @(posedge clk_i);
        rd(astr_pkg::OFS_FLAGS, 8'h10, "frozen rx");
        u_peer.send(9'h0c5, 9, 1'b1);
        rd(astr_pkg::OFS_RXDATA, 8'hc5, "rx after wake");
        $display("test halt done");
        report_and_stop;
    end
endmodule // testbench
